// [pstg_top.sv]
// Bank of ten programmable threshold stages with register port
//
// Chosen here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module pstg_top #(
	parameter int TICK_CYCLES = pstg_pkg::TICK_CYCLES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	input wire logic meas_valid,
	input wire logic [2:0] measurement_category,
	input wire logic [4:0] measurement_choice,
	input wire logic [pstg_pkg::VAL_W-1:0] meas_value,
	input wire logic group_sel,
	output logic [pstg_pkg::STAGES-1:0] stage_start,
	output logic [pstg_pkg::STAGES-1:0] stage_trip
);
	import pstg_pkg::*;

	typedef struct packed {
		logic activated;
		logic [3:0] stage_instance_count;
		logic allow_mode;
		logic force_en;
		logic [STAGES-1:0] stage_enable;
		logic [STAGES-1:0][2:0] stage_operating_mode;
		logic [STAGES-1:0][2:0] stage_forced_status;
		logic [STAGES-1:0][1:0] magnitude_count_select;
		logic [STAGES-1:0][2:0] magnitude_combine_op;
		logic [STAGES-1:0][1:0] crit;
		logic [STAGES-1:0][2:0][7:0] sel;
		logic [STAGES-1:0][2:0][MULT_W-1:0] measurement_scale_factor;
		logic [1:0][STAGES-1:0][2:0][VAL_W-1:0] thr;
		logic [1:0][STAGES-1:0][DLY_W-1:0] dly;
		logic [STAGES-1:0][2:0][VAL_W-1:0] val;
		logic [STAGES-1:0][VAL_W-1:0] prev;
		logic [STAGES-1:0][DLY_W-1:0] tmr;
		logic [STAGES-1:0] pick;
		logic [STAGES-1:0][2:0] cond;
		logic [TICK_W-1:0] tick_cnt;
		logic scan_act;
		logic [3:0] scan;
		logic [31:0] rdata;
		logic [STAGES-1:0] start_o;
		logic [STAGES-1:0] trip_o;
	} pstg_state_t;

	pstg_state_t q, d;
	logic pu;
	logic signed [VAL_W-1:0] cur_value;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	// Effective mode: the stage's own mode only when per-stage modes are allowed
	function automatic logic [2:0] eff_mode(input logic allow, input logic [2:0] m);
		return allow ? m : PSTG_ON;
	endfunction : eff_mode

	// Stage is live when activated, within the count, enabled and not off
	function automatic logic stage_live(input pstg_state_t s, input logic [3:0] k);
		return s.activated && (k < s.stage_instance_count) && s.stage_enable[k] &&
			(eff_mode(s.allow_mode, s.stage_operating_mode[k]) != PSTG_OFF);
	endfunction : stage_live

	// Shared evaluator, driven by the stage under scan
	pstg_eval u_eval (
		.nmag(q.magnitude_count_select[q.scan]),
		.op(q.magnitude_combine_op[q.scan]),
		.crit(q.crit[q.scan]),
		.v1(q.val[q.scan][0]),
		.v2(q.val[q.scan][1]),
		.v3(q.val[q.scan][2]),
		.m1(q.measurement_scale_factor[q.scan][0]),
		.m2(q.measurement_scale_factor[q.scan][1]),
		.m3(q.measurement_scale_factor[q.scan][2]),
		.t1(q.thr[group_sel][q.scan][0]),
		.t2(q.thr[group_sel][q.scan][1]),
		.t3(q.thr[group_sel][q.scan][2]),
		.prev(q.prev[q.scan]),
		.pickup(pu),
		.value(cur_value)
	);

	// Next-state logic: measurement capture, register access, periodic scan
	always_comb begin
		logic [3:0] ws;
		logic [3:0] ri;
		logic [3:0] si;
		logic [3:0] cnt;
		logic [1:0] k;
		logic [2:0] beh;
		logic [2:0] nc;
		logic [DLY_W-1:0] dl;
		logic [DLY_W-1:0] nt;
		logic live;
		d = q;
		ws = addr[7:4];
		ri = addr[3:0];
		si = q.scan;
		cnt = 4'h0;
		k = 2'h0;
		beh = 3'h0;
		nc = 3'h0;
		dl = '0;
		nt = '0;
		live = 1'b0;
		d.rdata = 32'h00000000;
		// Latch a measurement whenever its category and choice match a selection
		for (int s = 0; s < STAGES; s++) begin
			for (int m = 0; m < 3; m++) begin
				if (meas_valid && q.sel[s][m] == {measurement_category, measurement_choice}) begin
					d.val[s][m] = meas_value;
				end
			end
		end
		// Register writes; general settings are kept apart from group settings
		if (wr) begin
			if (ws == GLOBAL_STAGE && ri == R_GLOBAL) begin
				d.activated = wdata[GLB_ACT_BIT];
				cnt = wdata[GLB_CNT_LSB +: 4];
				if (cnt == 4'h0) begin
					cnt = RST_COUNT;
				end else if (cnt > MAX_COUNT) begin
					cnt = MAX_COUNT;
				end
				d.stage_instance_count = cnt;
				d.allow_mode = wdata[GLB_ALLOW_BIT];
				d.force_en = wdata[GLB_FORCE_BIT];
			end else if (ws < 4'(STAGES)) begin
				if (ri == R_CTRL) begin
					d.stage_enable[ws] = wdata[CTRL_EN_BIT];
					if (q.allow_mode) begin
						d.stage_operating_mode[ws] = (wdata[CTRL_MODE_LSB +: 3] > PSTG_OFF) ? PSTG_OFF :
							wdata[CTRL_MODE_LSB +: 3];
					end
					d.stage_forced_status[ws] = wdata[CTRL_FORCE_LSB +: 3];
					d.magnitude_count_select[ws] = (wdata[CTRL_NMAG_LSB +: 2] == 2'h0) ? RST_NMAG :
						wdata[CTRL_NMAG_LSB +: 2];
					d.magnitude_combine_op[ws] = wdata[CTRL_OP_LSB +: 3];
					d.crit[ws] = wdata[CTRL_CRIT_LSB +: 2];
				end else if (ri == R_SEL) begin
					d.sel[ws] = wdata[23:0];
				end else if (ri >= R_MULT1 && ri < R_THRA1) begin
					k = 2'(ri - R_MULT1);
					d.measurement_scale_factor[ws][k] = wdata[MULT_W-1:0];
				end else if (ri >= R_THRA1 && ri < R_DLYA) begin
					k = 2'(ri - R_THRA1);
					d.thr[0][ws][k] = wdata;
				end else if (ri == R_DLYA) begin
					d.dly[0][ws] = wdata[DLY_W-1:0];
				end else if (ri >= R_THRB1 && ri < R_DLYB) begin
					k = 2'(ri - R_THRB1);
					d.thr[1][ws][k] = wdata;
				end else if (ri == R_DLYB) begin
					d.dly[1][ws] = wdata[DLY_W-1:0];
				end
			end
		end
		// Register reads, answered in the following cycle
		if (rd) begin
			if (ws == GLOBAL_STAGE && ri == R_GLOBAL) begin
				d.rdata[GLB_ACT_BIT] = q.activated;
				d.rdata[GLB_CNT_LSB +: 4] = q.stage_instance_count;
				d.rdata[GLB_ALLOW_BIT] = q.allow_mode;
				d.rdata[GLB_FORCE_BIT] = q.force_en;
			end else if (ws < 4'(STAGES)) begin
				live = stage_live(q, ws);
				dl = q.dly[group_sel][ws];
				if (ri == R_CTRL) begin
					d.rdata[CTRL_EN_BIT] = q.stage_enable[ws];
					d.rdata[CTRL_MODE_LSB +: 3] = q.stage_operating_mode[ws];
					d.rdata[CTRL_FORCE_LSB +: 3] = q.stage_forced_status[ws];
					d.rdata[CTRL_NMAG_LSB +: 2] = q.magnitude_count_select[ws];
					d.rdata[CTRL_OP_LSB +: 3] = q.magnitude_combine_op[ws];
					d.rdata[CTRL_CRIT_LSB +: 2] = q.crit[ws];
				end else if (ri == R_SEL) begin
					d.rdata[23:0] = q.sel[ws];
				end else if (ri >= R_MULT1 && ri < R_THRA1) begin
					k = 2'(ri - R_MULT1);
					d.rdata[MULT_W-1:0] = q.measurement_scale_factor[ws][k];
				end else if (ri >= R_THRA1 && ri < R_DLYA) begin
					k = 2'(ri - R_THRA1);
					d.rdata = q.thr[0][ws][k];
				end else if (ri == R_DLYA) begin
					d.rdata[DLY_W-1:0] = q.dly[0][ws];
				end else if (ri >= R_THRB1 && ri < R_DLYB) begin
					k = 2'(ri - R_THRB1);
					d.rdata = q.thr[1][ws][k];
				end else if (ri == R_DLYB) begin
					d.rdata[DLY_W-1:0] = q.dly[1][ws];
				end else if (ri == R_STAT) begin
					d.rdata[2:0] = q.cond[ws];
					d.rdata[STAT_BEH_LSB +: 3] = eff_mode(q.allow_mode, q.stage_operating_mode[ws]);
				end else if (ri == R_OPT) begin
					d.rdata[DLY_W-1:0] = live ? dl : '0;
				end else if (ri == R_REM && live) begin
					d.rdata[DLY_W-1:0] = (q.tmr[ws] >= dl) ? '0 : DLY_W'(dl - q.tmr[ws]);
				end
			end
		end
		// Evaluation period counter; a sweep starts at each period boundary
		if (q.tick_cnt == TICK_W'(TICK_CYCLES - 1)) begin
			d.tick_cnt = '0;
			d.scan_act = 1'b1;
			d.scan = 4'h0;
		end else begin
			d.tick_cnt = TICK_W'(q.tick_cnt + 1'b1);
		end
		// One stage per cycle during a sweep
		if (q.scan_act) begin
			live = stage_live(q, si);
			beh = eff_mode(q.allow_mode, q.stage_operating_mode[si]);
			dl = q.dly[group_sel][si];
			d.prev[si] = cur_value;
			if (!live) begin
				d.pick[si] = 1'b0;
				d.tmr[si] = '0;
				nc = PSTG_C_DIS;
			end else begin
				d.pick[si] = pu;
				if (pu) begin
					nt = (q.tmr[si] < dl) ? DLY_W'(q.tmr[si] + 1'b1) : q.tmr[si];
				end else begin
					nt = '0;
				end
				d.tmr[si] = nt;
				if (beh == PSTG_BLOCKED || beh == PSTG_TESTBLK) begin
					nc = PSTG_C_BLOCK;
				end else if (pu && nt >= dl) begin
					nc = PSTG_C_TRIP;
				end else if (pu) begin
					nc = PSTG_C_START;
				end else begin
					nc = PSTG_C_NORMAL;
				end
			end
			// Forcing overrides the computed result
			if (q.force_en && q.activated && si < q.stage_instance_count &&
				q.stage_forced_status[si] != PSTG_F_NONE && q.stage_forced_status[si] <= PSTG_F_BLOCK) begin
				nc = q.stage_forced_status[si];
			end
			d.cond[si] = nc;
			d.start_o[si] = (nc == PSTG_C_START) || (nc == PSTG_C_TRIP);
			d.trip_o[si] = (nc == PSTG_C_TRIP);
			if (si == 4'(STAGES - 1)) begin
				d.scan_act = 1'b0;
			end else begin
				d.scan = 4'(si + 1'b1);
			end
		end
	end

	// State register with reset defaults
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
			q.stage_instance_count <= RST_COUNT;
			q.magnitude_count_select <= {STAGES{RST_NMAG}};
			q.measurement_scale_factor <= {3 * STAGES{RST_MULT}};
		end else begin
			q <= d;
		end
	end

	assign rdata = q.rdata;
	assign stage_start = q.start_o;
	assign stage_trip = q.trip_o;

	// Sweep start only at the period boundary
	period_start_a: assert property ($rose(q.scan_act) |-> $past(q.tick_cnt) == TICK_W'(TICK_CYCLES - 1))
		else $error("sweep started off the period boundary");
	// A sweep visits exactly ten stages, starting at stage zero
	sweep_length_a: assert property ($rose(q.scan_act) |-> q.scan == 4'h0 ##9
		(q.scan_act && q.scan == 4'(STAGES - 1)) ##1 !q.scan_act)
		else $error("sweep length is not ten cycles");
	// Within a sweep the stage index steps by one each cycle
	sweep_order_a: assert property (q.scan_act && q.scan != 4'(STAGES - 1)
		|=> q.scan_act && q.scan == 4'($past(q.scan) + 4'h1))
		else $error("sweep skipped a stage");
	// A trip is always accompanied by a start
	trip_has_start_a: assert property ((q.trip_o & ~q.start_o) == '0)
		else $error("trip without start");
	// A fresh pick-up with a delay above one period cannot trip at once
	early_trip_a: assert property (q.scan_act && !q.force_en && q.tmr[q.scan] == '0
		&& q.dly[group_sel][q.scan] > DLY_W'(1) |=> !stage_trip[$past(q.scan)])
		else $error("trip before the delay elapsed");
	// A stage not enabled reports disabled unless forced
	disabled_cond_a: assert property (q.scan_act && !q.stage_enable[q.scan] && !q.force_en
		|=> q.cond[$past(q.scan)] == PSTG_C_DIS)
		else $error("disabled stage shows other condition");
	// A stage not enabled keeps both outputs low unless forced
	disabled_out_a: assert property (q.scan_act && !q.stage_enable[q.scan] && !q.force_en
		|=> !stage_start[$past(q.scan)] && !stage_trip[$past(q.scan)])
		else $error("disabled stage raised an output");
	// Stages beyond the count never raise outputs
	hidden_stage_a: assert property (q.scan_act && q.scan >= q.stage_instance_count
		|=> !stage_start[$past(q.scan)] && !stage_trip[$past(q.scan)])
		else $error("hidden stage raised an output");
	// Stage count always stays within one to ten
	count_range_a: assert property (q.stage_instance_count >= RST_COUNT && q.stage_instance_count <= MAX_COUNT)
		else $error("stage count out of range");
	// Mode writes are ignored unless allowed
	mode_lock_a: assert property (wr && addr[7:4] < 4'(STAGES) && addr[3:0] == R_CTRL && !q.allow_mode
		|=> $stable(q.stage_operating_mode))
		else $error("mode changed while not allowed");
	// Blocked modes keep the outputs low unless forced
	blocked_quiet_a: assert property (q.scan_act && q.allow_mode && !q.force_en &&
		(q.stage_operating_mode[q.scan] == PSTG_BLOCKED || q.stage_operating_mode[q.scan] == PSTG_TESTBLK)
		|=> !stage_start[$past(q.scan)] && !stage_trip[$past(q.scan)])
		else $error("blocked stage raised an output");
	// Forced trip shows on the trip output
	forced_trip_a: assert property (q.scan_act && q.force_en && q.activated
		&& q.scan < q.stage_instance_count && q.stage_forced_status[q.scan] == PSTG_F_TRIP
		|=> stage_trip[$past(q.scan)])
		else $error("forced trip not shown");
	// Loss of pick-up clears the delay timer, and the trip unless forced
	timer_clear_a: assert property (q.scan_act && !pu |=> q.tmr[$past(q.scan)] == '0 &&
		(!stage_trip[$past(q.scan)] || q.force_en))
		else $error("timer not cleared on drop-off");
endmodule : pstg_top

// [pstg_pkg.sv]
// Package of constants and types for the programmable threshold stage bank
package pstg_pkg;
	// Sizes
	localparam int STAGES = 10;
	localparam int VAL_W = 32;
	localparam int MULT_W = 24;
	localparam int DLY_W = 16;
	localparam int TICK_W = 20;
	// Timing: 5 ms evaluation period at 100 MHz
	localparam int CYCLE_MS = 5;
	localparam int CLK_MHZ = 100;
	localparam int TICK_CYCLES = CYCLE_MS * CLK_MHZ * 1000;
	localparam int ROC_PER_S = 1000 / CYCLE_MS;
	// Operating and effective modes
	typedef enum logic [2:0] {
		PSTG_ON = 3'h0,
		PSTG_BLOCKED = 3'h1,
		PSTG_TEST = 3'h2,
		PSTG_TESTBLK = 3'h3,
		PSTG_OFF = 3'h4
	} pstg_mode_t;
	// Condition status
	typedef enum logic [2:0] {
		PSTG_C_DIS = 3'h0,
		PSTG_C_NORMAL = 3'h1,
		PSTG_C_START = 3'h2,
		PSTG_C_TRIP = 3'h3,
		PSTG_C_BLOCK = 3'h4
	} pstg_cond_t;
	// Forced status choices
	typedef enum logic [2:0] {
		PSTG_F_NONE = 3'h0,
		PSTG_F_NORMAL = 3'h1,
		PSTG_F_START = 3'h2,
		PSTG_F_TRIP = 3'h3,
		PSTG_F_BLOCK = 3'h4
	} pstg_force_t;
	// Pick-up criteria
	localparam logic [1:0] CRIT_OVER = 2'h0;
	localparam logic [1:0] CRIT_UNDER = 2'h1;
	localparam logic [1:0] CRIT_ROC = 2'h2;
	// Magnitude combine operations
	localparam logic [2:0] OP_MUL = 3'h0;
	localparam logic [2:0] OP_DIV = 3'h1;
	localparam logic [2:0] OP_SUB = 3'h2;
	localparam logic [2:0] OP_MAX = 3'h3;
	localparam logic [2:0] OP_MIN = 3'h4;
	localparam logic [2:0] OP_OR = 3'h5;
	localparam logic [2:0] OP_AND = 3'h6;
	localparam logic [2:0] OP_ORAND = 3'h7;
	// Register index within a stage; address is {stage, index}
	localparam logic [3:0] R_CTRL = 4'h0;
	localparam logic [3:0] R_SEL = 4'h1;
	localparam logic [3:0] R_MULT1 = 4'h2;
	localparam logic [3:0] R_THRA1 = 4'h5;
	localparam logic [3:0] R_DLYA = 4'h8;
	localparam logic [3:0] R_THRB1 = 4'h9;
	localparam logic [3:0] R_DLYB = 4'hC;
	localparam logic [3:0] R_STAT = 4'hD;
	localparam logic [3:0] R_OPT = 4'hE;
	localparam logic [3:0] R_REM = 4'hF;
	localparam logic [3:0] GLOBAL_STAGE = 4'hF;
	localparam logic [3:0] R_GLOBAL = 4'h0;
	// Field positions
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_MODE_LSB = 1;
	localparam int CTRL_FORCE_LSB = 4;
	localparam int CTRL_NMAG_LSB = 7;
	localparam int CTRL_OP_LSB = 9;
	localparam int CTRL_CRIT_LSB = 12;
	localparam int GLB_ACT_BIT = 0;
	localparam int GLB_CNT_LSB = 1;
	localparam int GLB_ALLOW_BIT = 5;
	localparam int GLB_FORCE_BIT = 6;
	localparam int STAT_BEH_LSB = 3;
	// Reset values and the maximum stage count
	localparam logic [MULT_W-1:0] RST_MULT = 24'h000001;
	localparam logic [1:0] RST_NMAG = 2'h1;
	localparam logic [3:0] RST_COUNT = 4'h1;
	localparam logic [3:0] MAX_COUNT = 4'hA;
endpackage : pstg_pkg

// [pstg_eval.sv]
// Combining and comparison arithmetic for one stage evaluation
`timescale 1ns/1ps
module pstg_eval (
	input wire logic [1:0] nmag,
	input wire logic [2:0] op,
	input wire logic [1:0] crit,
	input wire logic signed [pstg_pkg::VAL_W-1:0] v1,
	input wire logic signed [pstg_pkg::VAL_W-1:0] v2,
	input wire logic signed [pstg_pkg::VAL_W-1:0] v3,
	input wire logic signed [pstg_pkg::MULT_W-1:0] m1,
	input wire logic signed [pstg_pkg::MULT_W-1:0] m2,
	input wire logic signed [pstg_pkg::MULT_W-1:0] m3,
	input wire logic signed [pstg_pkg::VAL_W-1:0] t1,
	input wire logic signed [pstg_pkg::VAL_W-1:0] t2,
	input wire logic signed [pstg_pkg::VAL_W-1:0] t3,
	input wire logic signed [pstg_pkg::VAL_W-1:0] prev,
	output logic pickup,
	output logic signed [pstg_pkg::VAL_W-1:0] value
);
	import pstg_pkg::*;

	// Signed scaling of one magnitude, keeping the low word
	function automatic logic signed [VAL_W-1:0] scale(input logic signed [VAL_W-1:0] v,
		input logic signed [MULT_W-1:0] m);
		logic signed [VAL_W+MULT_W-1:0] p;
		p = v * m;
		return p[VAL_W-1:0];
	endfunction : scale

	// Threshold test for one value; rate criterion falls back to above here
	function automatic logic hit(input logic signed [VAL_W-1:0] v, input logic signed [VAL_W-1:0] t,
		input logic [1:0] c);
		return (c == CRIT_UNDER) ? (v < t) : (v > t);
	endfunction : hit

	logic signed [VAL_W-1:0] a, b, c;
	logic signed [3*VAL_W-1:0] prod;
	logic signed [VAL_W:0] diff;
	logic signed [VAL_W+16:0] rate;
	logic ha, hb, hc, logical;

	// Scale, combine and compare
	always_comb begin
		a = scale(v1, m1);
		b = scale(v2, m2);
		c = scale(v3, m3);
		ha = hit(a, t1, crit);
		hb = hit(b, t2, crit);
		hc = hit(c, t3, crit);
		prod = '0;
		value = a;
		logical = 1'b0;
		pickup = 1'b0;
		if (nmag == 2'h2) begin
			case (op)
				OP_MUL: begin
					prod = 96'(a) * 96'(b);
					value = prod[VAL_W-1:0];
				end
				OP_DIV: value = (b == '0) ? 32'sh7FFFFFFF : a / b;
				OP_SUB: value = a - b;
				OP_MAX: value = (a > b) ? a : b;
				OP_MIN: value = (a < b) ? a : b;
				OP_OR: begin
					logical = 1'b1;
					pickup = ha | hb;
				end
				OP_AND: begin
					logical = 1'b1;
					pickup = ha & hb;
				end
				default: value = a;
			endcase
		end else if (nmag == 2'h3) begin
			case (op)
				OP_MUL: begin
					prod = 96'(a) * 96'(b) * 96'(c);
					value = prod[VAL_W-1:0];
				end
				OP_MAX: value = (a > b) ? ((a > c) ? a : c) : ((b > c) ? b : c);
				OP_MIN: value = (a < b) ? ((a < c) ? a : c) : ((b < c) ? b : c);
				OP_OR: begin
					logical = 1'b1;
					pickup = ha | hb | hc;
				end
				OP_AND: begin
					logical = 1'b1;
					pickup = ha & hb & hc;
				end
				OP_ORAND: begin
					logical = 1'b1;
					pickup = (ha | hb) & hc;
				end
				default: value = a;
			endcase
		end
		// Rate of change per second from consecutive evaluations
		diff = 33'(value) - 33'(prev);
		rate = 49'(diff) * 49'(ROC_PER_S);
		if (!logical) begin
			case (crit)
				CRIT_OVER: pickup = value > t1;
				CRIT_UNDER: pickup = value < t1;
				CRIT_ROC: pickup = rate > 49'(t1);
				default: pickup = 1'b0;
			endcase
		end
	end
endmodule : pstg_eval

// [pstg_meas_src.sv]
// Behavioural source of analog measurement updates for the stage bank
`timescale 1ns/1ps
module pstg_meas_src (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic send,
	input wire logic [7:0] code,
	input wire logic [31:0] val,
	output logic meas_valid,
	output logic [2:0] measurement_category,
	output logic [4:0] measurement_choice,
	output logic [31:0] meas_value
);
	// One-cycle update pulse; between updates the lines toggle so stale values never look valid
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meas_valid <= 1'b0;
			{measurement_category, measurement_choice} <= 8'h00;
			meas_value <= 32'h00000000;
		end else if (send) begin
			meas_valid <= 1'b1;
			{measurement_category, measurement_choice} <= code;
			meas_value <= val;
		end else begin
			meas_valid <= 1'b0;
			{measurement_category, measurement_choice} <= ~{measurement_category, measurement_choice};
			meas_value <= ~meas_value;
		end
	end
endmodule : pstg_meas_src

// [pstg_top_tb.sv]
// Self-checking testbench for the programmable threshold stage bank
`timescale 1ns/1ps
module pstg_top_tb;
	import pstg_pkg::*;
	localparam int TK = 50;
	localparam int SWP = TK + 12;
	logic clk, rst_n, wr, rd, group_sel, send, meas_valid;
	logic [7:0] addr, code;
	logic [31:0] wdata, rdata, val;
	logic [2:0] measurement_category;
	logic [4:0] measurement_choice;
	logic [VAL_W-1:0] meas_value;
	logic [STAGES-1:0] stage_start, stage_trip;
	int n_fail, checked, n;
	// Combine cases: magnitude count, op, expected pick-up with values 6,3,2 and thresholds 5,4,1
	logic [5:0] tbl [13] = '{{2'h2, OP_MUL, 1'b1}, {2'h2, OP_DIV, 1'b0}, {2'h2, OP_SUB, 1'b0},
		{2'h2, OP_MAX, 1'b1}, {2'h2, OP_MIN, 1'b0}, {2'h2, OP_OR, 1'b1}, {2'h2, OP_AND, 1'b0},
		{2'h3, OP_MUL, 1'b1}, {2'h3, OP_MAX, 1'b1}, {2'h3, OP_MIN, 1'b0}, {2'h3, OP_OR, 1'b1},
		{2'h3, OP_AND, 1'b0}, {2'h3, OP_ORAND, 1'b1}};
	logic [2:0] cnd [5] = '{3'h3, 3'h4, 3'h3, 3'h4, 3'h0};
	logic [1:0] fx [4] = '{2'h0, 2'h2, 2'h3, 2'h0};

	// Clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	pstg_top #(.TICK_CYCLES(TK)) dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .meas_valid(meas_valid), .measurement_category(measurement_category),
		.measurement_choice(measurement_choice), .meas_value(meas_value), .group_sel(group_sel),
		.stage_start(stage_start), .stage_trip(stage_trip));

	pstg_meas_src src (.clk(clk), .rst_n(rst_n), .send(send), .code(code), .val(val), .meas_valid(meas_valid),
		.measurement_category(measurement_category), .measurement_choice(measurement_choice),
		.meas_value(meas_value));

	// Stage control word
	function automatic logic [31:0] ctl(input logic en, input logic [2:0] m, input logic [2:0] f,
		input logic [1:0] nm, input logic [2:0] op, input logic [1:0] cr);
		return {18'h0, cr, op, nm, f, m, en};
	endfunction : ctl

	// Global word, always activated
	function automatic logic [31:0] glb(input logic [3:0] cnt, input logic al, input logic fo);
		return {25'h0, fo, al, cnt, 1'b1};
	endfunction : glb

	// Verdict and end of run
	task automatic complete_run();
		$display("Checks %0d, mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : complete_run

	// Compare and count
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	// One-cycle register write
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wreg

	// Register read; data stands only in the cycle after the strobe
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdata, e);
	endtask : rchk

	// Measurement update through the source model
	task automatic meas(input logic [7:0] c, input logic [31:0] v);
		@(posedge clk);
		code <= c;
		val <= v;
		send <= 1'b1;
		@(posedge clk);
		send <= 1'b0;
	endtask : meas

	// Let whole evaluation periods pass
	task automatic sweeps(input int k);
		repeat (k * SWP) @(posedge clk);
		#1;
	endtask : sweeps

	// Bounded wait for start or trip of one stage
	task automatic wait_hi(input int i, input logic tr, input int lim);
		n = 0;
		while ((tr ? stage_trip[i] : stage_start[i]) !== 1'b1) begin
			@(posedge clk);
			#1;
			n++;
			if (n > lim) begin
				chk(32'h0, 32'h1);
				complete_run();
			end
		end
	endtask : wait_hi

	// End-of-test line with running counts
	task automatic endt(input string s);
		$display("%s done: checks %0d mismatches %0d", s, checked, n_fail);
	endtask : endt

	// Main sequence
	initial begin
		rst_n = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = 8'h00;
		wdata = 32'h0;
		group_sel = 1'b0;
		send = 1'b0;
		code = 8'h00;
		val = 32'h0;
		n_fail = 0;
		checked = 0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		rchk(8'hF0, 32'h2);
		rchk({4'h0, R_CTRL}, 32'h80);
		rchk({4'h0, R_MULT1}, 32'h1);
		rchk({4'h0, R_STAT}, 32'h0);
		rchk(8'hA0, 32'h0);
		wreg(8'hF0, glb(4'hF, 1'b0, 1'b0));
		rchk(8'hF0, glb(4'hA, 1'b0, 1'b0));
		wreg(8'hF0, glb(4'h1, 1'b0, 1'b0));
		endt("reset");
		wreg(8'h01, 32'h22);
		wreg(8'h05, 32'd100);
		wreg(8'h08, 32'd2);
		wreg(8'h09, 32'd300);
		wreg(8'h00, ctl(1'b1, 3'h0, 3'h0, 2'h1, OP_MUL, CRIT_OVER));
		meas(8'h22, 32'd200);
		wait_hi(0, 1'b0, 3 * SWP);
		chk(stage_trip[0], 1'b0);
		wait_hi(0, 1'b1, 2 * SWP);
		chk(n >= 40 && n <= 70, 1'b1);
		rchk(8'h0E, 32'd2);
		rchk(8'h0F, 32'd0);
		wreg(8'h08, 32'd8);
		meas(8'h22, 32'd50);
		sweeps(2);
		chk({stage_start[0], stage_trip[0]}, 2'h0);
		meas(8'h22, 32'd200);
		wait_hi(0, 1'b0, 3 * SWP);
		rchk(8'h0F, 32'd7);
		chk(stage_trip[0], 1'b0);
		endt("delay");
		@(posedge clk);
		group_sel <= 1'b1;
		sweeps(2);
		chk(stage_start[0], 1'b0);
		meas(8'h22, 32'd400);
		sweeps(2);
		chk(stage_trip[0], 1'b1);
		rchk(8'h00, ctl(1'b1, 3'h0, 3'h0, 2'h1, OP_MUL, CRIT_OVER));
		@(posedge clk);
		group_sel <= 1'b0;
		wreg(8'h08, 32'd0);
		endt("group");
		wreg(8'h00, ctl(1'b1, PSTG_BLOCKED, 3'h0, 2'h1, OP_MUL, CRIT_OVER));
		sweeps(2);
		rchk(8'h0D, 32'h3);
		wreg(8'hF0, glb(4'h1, 1'b1, 1'b0));
		for (int m = 0; m < 5; m++) begin
			wreg(8'h00, ctl(1'b1, 3'(m), 3'h0, 2'h1, OP_MUL, CRIT_OVER));
			sweeps(2);
			rchk(8'h0D, {26'h0, 3'(m), cnd[m]});
			chk(stage_trip[0], cnd[m] == 3'h3);
		end
		wreg(8'h00, ctl(1'b1, 3'h0, 3'h0, 2'h1, OP_MUL, CRIT_OVER));
		wreg(8'h02, 32'h00FFFFFF);
		sweeps(2);
		chk(stage_start[0], 1'b0);
		rchk(8'h02, 32'h00FFFFFF);
		endt("modes");
		wreg(8'h10, ctl(1'b1, 3'h0, 3'h0, 2'h1, OP_MUL, CRIT_OVER));
		wreg(8'h11, 32'h22);
		meas(8'h22, 32'd400);
		sweeps(2);
		chk(stage_start[1], 1'b0);
		wreg(8'hF0, glb(4'h2, 1'b1, 1'b0));
		sweeps(2);
		chk(stage_trip[1], 1'b1);
		wreg(8'h10, ctl(1'b0, 3'h0, 3'h0, 2'h1, OP_MUL, CRIT_OVER));
		sweeps(2);
		chk(stage_start[1], 1'b0);
		rchk(8'h1D, 32'h0);
		endt("count");
		wreg(8'hF0, glb(4'h5, 1'b1, 1'b1));
		for (int f = 1; f < 5; f++) begin
			wreg(8'h30, ctl(1'b0, 3'h0, 3'(f), 2'h1, OP_MUL, CRIT_OVER));
			sweeps(2);
			chk({stage_start[3], stage_trip[3]}, fx[f-1]);
			rchk(8'h3D, 32'(f));
		end
		endt("force");
		wreg(8'h21, 32'h030201);
		wreg(8'h25, 32'd5);
		wreg(8'h26, 32'd4);
		wreg(8'h27, 32'd1);
		meas(8'h01, 32'd6);
		meas(8'h02, 32'd3);
		meas(8'h03, 32'd2);
		for (int j = 0; j < 13; j++) begin
			wreg(8'h20, ctl(1'b1, 3'h0, 3'h0, tbl[j][5:4], tbl[j][3:1], CRIT_OVER));
			sweeps(2);
			chk(stage_start[2], tbl[j][0]);
		end
		endt("combine");
		wreg(8'h41, 32'h41);
		wreg(8'h45, 32'd1000);
		wreg(8'h40, ctl(1'b1, 3'h0, 3'h0, 2'h1, OP_MUL, CRIT_ROC));
		meas(8'h41, 32'd0);
		sweeps(2);
		chk(stage_start[4], 1'b0);
		meas(8'h41, 32'd10);
		wait_hi(4, 1'b0, 2 * SWP);
		chk(n <= SWP, 1'b1);
		sweeps(2);
		chk(stage_start[4], 1'b0);
		meas(8'h42, 32'd100);
		sweeps(2);
		chk(stage_start[4], 1'b0);
		endt("rate");
		complete_run();
	end
endmodule : pstg_top_tb
